// File: core/fcd_cfg.svh
// constants for the fieldbus control word decoder
`ifndef FCD_CFG_SVH
`define FCD_CFG_SVH
`define FCD_BIT_OP_PERMIT   0
`define FCD_BIT_CLOSE_PERM  1
`define FCD_BIT_HALT_N      2
`define FCD_BIT_START       3
`define FCD_BIT_CHARGE_REQ  4
`define FCD_BIT_FAULT_ACK   7
`define FCD_WORD_RESET      16'h0000
`define FCD_MODE_LEVEL      1'h0
`define FCD_MODE_EDGE       1'h1
`endif

// File: core/fcd_decoder.sv
// fieldbus control word decoder top
`include "fcd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        word_we,
  input  wire logic [15:0] remote_command_word,
  input  wire logic        fieldbus_active,
  input  wire logic        start_mode,
  input  wire logic        app_precharge,
  input  wire logic        halt_exception_en,
  input  wire logic        charge_done,
  input  wire logic        breaker_closed,
  input  wire logic        start_blocked,
  output logic             precharge_on,
  output logic             main_breaker_close,
  output logic             main_breaker_open,
  output logic             modulate,
  output logic             quick_stop_exc,
  output logic             event_reset,
  output logic             switch_on_inhibited_state,
  output logic             ready_to_switch_on_state
);
  fcd_edge_if ei ();

  fcd_edge u_edge (
    .clk     (clk),
    .reset   (reset),
    .word_we (word_we),
    .word_in (remote_command_word),
    .eo      (ei.src)
  );

  ////////////////////////////////////////////////////////////////////
  // decoded bits, reserved positions unused
  logic op_permit, close_permit, halt_req, start_bit, charge_req;
  always_comb begin
    op_permit    = ei.word[`FCD_BIT_OP_PERMIT] & fieldbus_active;
    close_permit = ei.word[`FCD_BIT_CLOSE_PERM] & fieldbus_active;
    halt_req     = ~ei.word[`FCD_BIT_HALT_N] & fieldbus_active;
    start_bit    = ei.word[`FCD_BIT_START] & fieldbus_active;
    charge_req   = ei.word[`FCD_BIT_CHARGE_REQ] & fieldbus_active;
  end

  ////////////////////////////////////////////////////////////////////
  // switch-on state machine
  fcd_pkg::fcd_state_t state_q, state_d;
  logic seen_low_q, seen_low_d;
  logic armed_q, armed_d;
  logic start_ok, edge_now;

  always_comb begin
    edge_now = ei.start_rise & fieldbus_active;
    state_d  = state_q;
    seen_low_d = seen_low_q;
    armed_d  = armed_q;
    if (!op_permit) seen_low_d = 1'b1;
    if (edge_now) armed_d = 1'b1;
    if (!start_bit) armed_d = 1'b0;
    // level mode start_ok is the level alone; going from READY to CHARGING still needs a start edge in both modes
    start_ok = (start_mode == `FCD_MODE_EDGE) ? (armed_q | edge_now) & start_bit : start_bit;
    unique case (state_q)
      fcd_pkg::FCD_INHIBITED: begin
        if (seen_low_q && op_permit && close_permit && !halt_req) begin
          state_d = fcd_pkg::FCD_READY;
          seen_low_d = 1'b0;
        end
      end
      fcd_pkg::FCD_READY: begin
        if (start_ok && edge_now && !start_blocked) begin
          state_d = fcd_pkg::FCD_CHARGING;
        end else if (edge_now && start_mode == `FCD_MODE_EDGE) begin
          armed_d = 1'b0;
        end
      end
      fcd_pkg::FCD_CHARGING: if (charge_done) state_d = fcd_pkg::FCD_CLOSING;
      fcd_pkg::FCD_CLOSING:  if (breaker_closed) state_d = fcd_pkg::FCD_RUNNING;
      fcd_pkg::FCD_RUNNING:  state_d = fcd_pkg::FCD_RUNNING;
      default:               state_d = fcd_pkg::FCD_INHIBITED;
    endcase
    if (state_q != fcd_pkg::FCD_INHIBITED && state_q != fcd_pkg::FCD_READY) begin
      if (!start_bit || halt_req) state_d = fcd_pkg::FCD_READY;
      if (!op_permit || !close_permit) state_d = fcd_pkg::FCD_INHIBITED;
    end else if (state_q == fcd_pkg::FCD_READY && (!op_permit || !close_permit)) begin
      state_d = fcd_pkg::FCD_INHIBITED;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q    <= fcd_pkg::FCD_INHIBITED;
      seen_low_q <= 1'b0;
      armed_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      seen_low_q <= seen_low_d;
      armed_q    <= armed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // output controls
  logic pc_d, cl_d, op_d, mod_d, exc_d, er_d, inh_d, rdy_d;
  logic pc_q, cl_q, op_q, mod_q, exc_q, er_q, inh_q, rdy_q;

  always_comb begin
    pc_d  = (state_q == fcd_pkg::FCD_CHARGING) & op_permit & start_bit;
    if (app_precharge) pc_d = op_permit & charge_req;
    cl_d  = (state_q == fcd_pkg::FCD_CLOSING || state_q == fcd_pkg::FCD_RUNNING)
            & op_permit & close_permit;
    op_d  = breaker_closed & (!op_permit | !close_permit);
    mod_d = (state_q == fcd_pkg::FCD_RUNNING) & op_permit & close_permit
            & start_bit & !halt_req;
    exc_d = halt_req & halt_exception_en;
    er_d  = ei.ack_rise & fieldbus_active;
    inh_d = (state_d == fcd_pkg::FCD_INHIBITED);
    rdy_d = (state_d == fcd_pkg::FCD_READY);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pc_q  <= 1'b0;
      cl_q  <= 1'b0;
      op_q  <= 1'b0;
      mod_q <= 1'b0;
      exc_q <= 1'b0;
      er_q  <= 1'b0;
      inh_q <= 1'b1;
      rdy_q <= 1'b0;
    end else begin
      pc_q  <= pc_d;
      cl_q  <= cl_d;
      op_q  <= op_d;
      mod_q <= mod_d;
      exc_q <= exc_d;
      er_q  <= er_d;
      inh_q <= inh_d;
      rdy_q <= rdy_d;
    end
  end

  assign precharge_on              = pc_q;
  assign main_breaker_close        = cl_q;
  assign main_breaker_open         = op_q;
  assign modulate                  = mod_q;
  assign quick_stop_exc            = exc_q;
  assign event_reset               = er_q;
  assign switch_on_inhibited_state = inh_q;
  assign ready_to_switch_on_state  = rdy_q;

  ////////////////////////////////////////////////////////////////////
  // checks
  chk_permit_blocks_mod: assert property (@(posedge clk) disable iff (reset)
    !op_permit |=> !modulate) else $error("modulation while permit low");
  chk_permit_opens_brk: assert property (@(posedge clk) disable iff (reset)
    (!op_permit && breaker_closed) |=> main_breaker_open) else $error("breaker not opened");
  chk_fall_stops_run: assert property (@(posedge clk) disable iff (reset)
    (state_q == fcd_pkg::FCD_RUNNING && !op_permit) |=> state_q == fcd_pkg::FCD_INHIBITED)
    else $error("run not stopped");
  chk_inhibit_needs_low: assert property (@(posedge clk) disable iff (reset)
    (state_q == fcd_pkg::FCD_INHIBITED && !seen_low_q) |=> state_q == fcd_pkg::FCD_INHIBITED)
    else $error("left inhibited without permit low");
  chk_close_perm_brk: assert property (@(posedge clk) disable iff (reset)
    !close_permit |=> !main_breaker_close && !modulate) else $error("close permit ignored");
  chk_close_withdrawn: assert property (@(posedge clk) disable iff (reset)
    (state_q != fcd_pkg::FCD_INHIBITED && !close_permit) |=> state_q == fcd_pkg::FCD_INHIBITED)
    else $error("close permit loss not inhibiting");
  chk_halt_stops_mod: assert property (@(posedge clk) disable iff (reset)
    halt_req |=> !modulate) else $error("modulation during halt");
  chk_start_low_stops: assert property (@(posedge clk) disable iff (reset)
    (!start_bit && op_permit && close_permit && state_q > fcd_pkg::FCD_READY)
    |=> state_q == fcd_pkg::FCD_READY) else $error("start low not stopping");
  chk_charge_on_edge: assert property (@(posedge clk) disable iff (reset)
    (state_q == fcd_pkg::FCD_READY && $past(state_q) == fcd_pkg::FCD_READY
     && state_d == fcd_pkg::FCD_CHARGING) |-> edge_now) else $error("charge without edge");
  chk_ack_event: assert property (@(posedge clk) disable iff (reset)
    (ei.ack_rise && fieldbus_active) |=> event_reset ##1 !event_reset)
    else $error("event reset not single pulse");
endmodule : fcd_decoder
`default_nettype wire

// File: core/fcd_edge.sv
// accepted word register and edge detection
`include "fcd_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module fcd_edge (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        word_we,
  input  wire logic [15:0] word_in,
  fcd_edge_if.src          eo
);
  logic [15:0] word_q, word_d;
  logic [15:0] prev_q, prev_d;
  logic        sr_q, sr_d, ar_q, ar_d, pf_q, pf_d;

  always_comb begin
    word_d = word_q;
    prev_d = prev_q;
    sr_d   = 1'b0;
    ar_d   = 1'b0;
    pf_d   = 1'b0;
    if (word_we) begin
      prev_d = word_q;
      word_d = word_in;
      sr_d = word_in[`FCD_BIT_START] & ~word_q[`FCD_BIT_START];
      ar_d = word_in[`FCD_BIT_FAULT_ACK] & ~word_q[`FCD_BIT_FAULT_ACK];
      pf_d = ~word_in[`FCD_BIT_OP_PERMIT] & word_q[`FCD_BIT_OP_PERMIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      word_q <= `FCD_WORD_RESET;
      prev_q <= `FCD_WORD_RESET;
      sr_q   <= 1'b0;
      ar_q   <= 1'b0;
      pf_q   <= 1'b0;
    end else begin
      word_q <= word_d;
      prev_q <= prev_d;
      sr_q   <= sr_d;
      ar_q   <= ar_d;
      pf_q   <= pf_d;
    end
  end

  assign eo.word        = word_q;
  assign eo.start_rise  = sr_q;
  assign eo.ack_rise    = ar_q;
  assign eo.permit_fall = pf_q;

  chk_ack_single_pulse: assert property (@(posedge clk) disable iff (reset)
    ar_q |=> !ar_q) else $error("fault ack pulse longer than one cycle");
endmodule : fcd_edge
`default_nettype wire

// File: core/fcd_edge_if.sv
// decoded word bits and their edges
`timescale 1ns/1ns
`default_nettype none
interface fcd_edge_if;
  logic [15:0] word;
  logic        start_rise;
  logic        ack_rise;
  logic        permit_fall;
  modport src (output word, output start_rise, output ack_rise, output permit_fall);
  modport dst (input word, input start_rise, input ack_rise, input permit_fall);
endinterface : fcd_edge_if
`default_nettype wire

// File: core/fcd_pkg.sv
// types of the fieldbus control word decoder
package fcd_pkg;
  typedef enum logic [2:0] {
    FCD_INHIBITED = 3'h0,
    FCD_READY     = 3'h1,
    FCD_CHARGING  = 3'h2,
    FCD_CLOSING   = 3'h3,
    FCD_RUNNING   = 3'h4
  } fcd_state_t;
endpackage : fcd_pkg

// File: verif/fcd_decoder_test.sv
// self-checking bench of the control word decoder
`timescale 1ns/1ns
`default_nettype none
module fcd_decoder_test;
  logic        clk, reset, req, dirty, fb_act, smode, app_pc, exc_en;
  logic        chg_done, brk_closed, blocked, word_we;
  logic        pc_on, brk_cl, brk_op, mod, qs_exc, ev_rst, inh, rdy;
  logic [15:0] req_word, seed, rcw;
  logic [7:0]  ev_cnt, ev_base;
  int          mismatches, n_tests;
  fcd_master_model u_mst (.clk(clk), .reset(reset), .req(req), .dirty(dirty),
    .req_word(req_word), .word_we(word_we), .remote_command_word(rcw));
  fcd_decoder u_dut (.clk(clk), .reset(reset), .word_we(word_we), .remote_command_word(rcw),
    .fieldbus_active(fb_act), .start_mode(smode), .app_precharge(app_pc),
    .halt_exception_en(exc_en), .charge_done(chg_done), .breaker_closed(brk_closed),
    .start_blocked(blocked), .precharge_on(pc_on), .main_breaker_close(brk_cl),
    .main_breaker_open(brk_op), .modulate(mod), .quick_stop_exc(qs_exc),
    .event_reset(ev_rst), .switch_on_inhibited_state(inh), .ready_to_switch_on_state(rdy));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (reset) ev_cnt <= 8'h00;
    else if (ev_rst === 1'b1) ev_cnt <= ev_cnt + 8'h01;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] base);
    seed = nxt(seed);
    @(posedge clk);
    req      <= 1'b1;
    req_word <= base | (seed & 16'hfc00);
    @(posedge clk);
    req <= 1'b0;
    repeat (5) @(posedge clk);
  endtask : wr
  task automatic fb(input logic c, input logic b);
    chg_done   <= c;
    brk_closed <= b;
    repeat (5) @(posedge clk);
  endtask : fb
  task automatic up();
    fb(1'b0, 1'b0);
    wr(16'h0006);
    wr(16'h0007);
    chk(rdy, 8'h01);
    wr(16'h000f);
    chk(pc_on, 8'h01);
    fb(1'b1, 1'b0);
    chk(brk_cl, 8'h01);
    fb(1'b1, 1'b1);
    chk(mod, 8'h01);
  endtask : up
  task automatic end_sim();
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    {reset, req, dirty, smode, app_pc, exc_en, chg_done, brk_closed, blocked} = 9'h100;
    fb_act = 1'b1;
    req_word = 16'h0000;
    seed = 16'h0062;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({inh, rdy, pc_on, brk_cl, brk_op, mod, qs_exc, ev_rst}, 8'h80);
    up();
    exc_en <= 1'b1;
    wr(16'h000b);
    chk(mod, 8'h00);
    chk(qs_exc, 8'h01);
    wr(16'h000f);
    chk(pc_on, 8'h00);
    up();
    wr(16'h0007);
    chk(mod, 8'h00);
    up();
    wr(16'h000e);
    chk({mod, brk_cl, brk_op, inh}, 8'h03);
    up();
    wr(16'h000d);
    chk({mod, brk_op, inh}, 8'h03);
    fb(1'b0, 1'b0);
    wr(16'h0006);
    wr(16'h0007);
    wr(16'h000f);
    wr(16'h0007);
    chk(pc_on, 8'h00);
    smode   <= 1'b1;
    blocked <= 1'b1;
    wr(16'h000f);
    chk(pc_on, 8'h00);
    blocked <= 1'b0;
    wr(16'h000f);
    chk(pc_on, 8'h00);
    wr(16'h0007);
    wr(16'h000f);
    chk(pc_on, 8'h01);
    smode <= 1'b0;
    wr(16'h0006);
    wr(16'h0007);
    app_pc <= 1'b1;
    wr(16'h0017);
    chk(pc_on, 8'h01);
    wr(16'h0007);
    chk(pc_on, 8'h00);
    app_pc  <= 1'b0;
    ev_base = ev_cnt;
    wr(16'h0087);
    wr(16'h0087);
    wr(16'h0007);
    wr(16'h0087);
    chk(ev_cnt, ev_base + 8'h02);
    dirty <= 1'b1;
    wr(16'h0367);
    chk({rdy, pc_on}, 8'h02);
    dirty  <= 1'b0;
    fb_act <= 1'b0;
    ev_base = ev_cnt;
    wr(16'h008f);
    chk(pc_on, 8'h00);
    chk(ev_cnt, ev_base);
    end_sim();
  end
endmodule : fcd_decoder_test
`default_nettype wire

// File: verif/fcd_master_model.sv
// fieldbus master model writing the control word
`timescale 1ns/1ns
`default_nettype none
module fcd_master_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        req,
  input  wire logic        dirty,
  input  wire logic [15:0] req_word,
  output logic             word_we,
  output logic [15:0]      remote_command_word
);
  always_ff @(posedge clk) begin
    if (reset) begin
      word_we             <= 1'h0;
      remote_command_word <= 16'h0000;
    end else begin
      word_we <= req;
      if (req) begin
        remote_command_word <= dirty ? req_word : (req_word & 16'hfc9f);
      end else begin
        remote_command_word <= ~remote_command_word;
      end
    end
  end
endmodule : fcd_master_model
`default_nettype wire
